// ===== rtl/eeprom_map_consts.vh
`ifndef EEPROM_MAP_CONSTS_VH
`define EEPROM_MAP_CONSTS_VH

// ***************************************************************
// command codes on the transaction port
// ***************************************************************
`define CMD_READ_MEM     4'h1
`define CMD_SP_WRITE     4'h2
`define CMD_SP_READ      4'h3
`define CMD_SP_COPY      4'h4
`define CMD_PIN_WRITE    4'h5
`define CMD_ACT_RESET    4'h6
`define CMD_REG_WRITE    4'h7
`define CMD_ID_BIT       4'h8

// ***************************************************************
// address map
// ***************************************************************
`define ADDR_PROT_BASE   10'h200
`define ADDR_LOCK        10'h210
`define ADDR_FACTORY     10'h211
`define ADDR_RSVD_FIRST  10'h212
`define ADDR_RSVD_LAST   10'h21D
`define ADDR_TRAILER0    10'h21E
`define ADDR_TRAILER1    10'h21F
`define ADDR_PIN_LEVEL   10'h220
`define ADDR_OUT_LATCH   10'h221
`define ADDR_ACTIVITY    10'h222
`define ADDR_SRCH_MASK   10'h223
`define ADDR_SRCH_POL    10'h224
`define ADDR_SRCH_CTRL   10'h225
`define MEM_BYTES        544

// ***************************************************************
// codes, field positions and reset values
// ***************************************************************
`define CODE_WP          8'h55
`define CODE_EPROM       8'hAA
`define STAT_BLOCKED     8'hFF
`define STAT_DONE        8'hAA
`define ERASED_BYTE      8'hFF
`define CTRL_PLS_BIT     0
`define CTRL_CT_BIT      1
`define CTRL_PORL_BIT    3
`define CTRL_POL_BIT     6
`define CTRL_VCCP_BIT    7
`define CTRL_WR_MASK     8'h0B
`define SRCH_WR_MASK     8'h03
`define PIN_FILL_HI      6'h3F
`define CRC_POLY_REFL    8'h8C

`endif

// ===== rtl/eeprom_page_protection_map.v
`timescale 1ns/1ps
`include "eeprom_map_consts.vh"

// Summary of operation
// - memory commands only after an addressing command
// - overdrive addressing command switches to fast timing
// - all bytes move least significant bit first
// - identity: family, address byte, serial, check
// - address byte low bits follow straps, top 0
// - check byte is fixed crc, straps as ones
// - reads unrestricted from 0000h through 021Fh
// - sixteen 32-byte pages, code at 0200h plus n
// - code 55h makes page write protected
// - code AAh makes page EPROM emulation
// - lock 55h/AAh copy-protects WP pages, register page
// - codes 55h/AAh lock themselves, others inert
// - writes go via 32-byte scratchpad, then copy
// - scratchpad write to WP stores existing byte
// - scratchpad write to EPROM stores AND
// - copy to WP or EPROM page still executes
// - copy to copy-protected page blocked, FFh status
// - reserved bytes inert; factory byte fixed
// - pin registers volatile, read like memory
// - pin level register: two pins, upper ones
// - pin levels sampled at preceding byte end
// - only search registers written, by own command
// - output latch read-only, pin writes, polarity powerup
// - activity latch sets on edges, clears to 00h
module eeprom_page_protection_map #(
  parameter [7:0]  FAMILY_CODE   = 8'h5A, // arbitrary value
  parameter [39:0] SERIAL_NUMBER = 40'h0123456789, // arbitrary value
  parameter [7:0]  FACTORY_BYTE  = 8'h55,
  parameter [7:0]  TRAILER_BYTE0 = 8'hFF,
  parameter [7:0]  TRAILER_BYTE1 = 8'hFF
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [6:0] strap_bits,
  input  wire       powerup_polarity_strap,
  input  wire       vcc_present,
  input  wire       gp_pin_zero_in,
  input  wire       gp_pin_one_in,
  output reg        gp_pin_zero_out,
  output reg        gp_pin_zero_oe,
  output reg        gp_pin_one_out,
  output reg        gp_pin_one_oe,
  input  wire       bus_reset,
  input  wire       rom_done,
  input  wire       rom_overdrive,
  input  wire       byte_end,
  input  wire       cmd_valid,
  input  wire [3:0] cmd_code,
  input  wire [9:0] cmd_addr,
  input  wire [7:0] cmd_data,
  output reg        resp_valid,
  output reg [7:0]  resp_data,
  output reg        cmd_refused,
  output reg        busy,
  output reg        overdrive,
  output reg        search_match
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_COPY = 2'h1;

  // ***************************************************************
  // functions
  // ***************************************************************
  // crc over 56 bits, lsb first, x^8+x^5+x^4+1
  function [7:0] crc56;
    input [55:0] bits;
    integer i;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (i = 0; i < 56; i = i + 1) begin
        if (c[0] ^ bits[i])
          c = (c >> 1) ^ `CRC_POLY_REFL;
        else
          c = c >> 1;
      end
      crc56 = c;
    end
  endfunction

  function is_lock_code;
    input [7:0] v;
    begin
      is_lock_code = (v == `CODE_WP) || (v == `CODE_EPROM);
    end
  endfunction

  // ***************************************************************
  // storage and state
  // ***************************************************************
  reg  [7:0] mem_ff [0:`MEM_BYTES-1];
  reg  [7:0] pad_ff [0:31];
  reg  [1:0] state_ff;
  reg        granted_ff;
  reg  [9:0] ta_ff;
  reg  [4:0] end_ff;
  reg  [4:0] cp_off_ff;
  reg        pad_fresh_ff;
  reg        cp_blocked_ff;
  reg  [1:0] pin_s1_ff;
  reg  [1:0] pin_s2_ff;
  reg  [1:0] pin_d_ff;
  reg  [1:0] pin_snap_ff;
  reg  [6:0] strap_s1_ff;
  reg  [6:0] strap_s2_ff;
  reg  [1:0] pol_s1_ff;
  reg  [1:0] pol_s2_ff;
  reg  [1:0] out_latch_ff;
  reg  [1:0] activity_ff;
  reg  [1:0] srch_mask_ff;
  reg  [1:0] srch_pol_ff;
  reg  [7:0] srch_ctrl_ff;
  reg        pol_caught_ff;
  integer    k;

  wire       pol_level = pol_s2_ff[0];
  wire       vcc_level = pol_s2_ff[1];

  // identity word, sent byte 0 first, each byte lsb first
  wire [55:0] id_fixed = {SERIAL_NUMBER, 8'h7F, FAMILY_CODE};
  wire [7:0]  id_crc   = crc56(id_fixed);
  wire [63:0] id_word  = {id_crc, SERIAL_NUMBER, 1'b0, strap_s2_ff,
                          FAMILY_CODE};

  // ***************************************************************
  // protection decode for the target of a scratchpad write
  // ***************************************************************
  wire [3:0] tgt_page  = cmd_addr[8:5];
  wire [7:0] page_code = mem_ff[`ADDR_PROT_BASE + {6'h00, tgt_page}];
  wire       tgt_data  = (cmd_addr < `ADDR_PROT_BASE);
  wire       tgt_ctrl  = (cmd_addr <= `ADDR_LOCK) && !tgt_data;
  wire [7:0] old_byte  = (cmd_addr < `MEM_BYTES) ? mem_ff[cmd_addr]
                                                  : `ERASED_BYTE;
  // a control byte guards itself; the rest of that page is fixed
  wire       tgt_wp    = tgt_data ? (page_code == `CODE_WP)
                       : tgt_ctrl ? is_lock_code(old_byte)
                       : 1'b1;
  wire       tgt_eprom = tgt_data && (page_code == `CODE_EPROM);
  wire [7:0] pad_value = tgt_wp    ? old_byte
                       : tgt_eprom ? (old_byte & cmd_data)
                       : cmd_data;

  // copy protection for the page latched in the target register
  wire [7:0] ta_code   = mem_ff[`ADDR_PROT_BASE + {6'h00, ta_ff[8:5]}];
  wire       lock_on   = is_lock_code(mem_ff[`ADDR_LOCK]);
  wire       ta_regpg  = (ta_ff >= `ADDR_PROT_BASE);
  // EPROM pages are deliberately left out of copy protection
  wire       ta_cprot  = lock_on &&
                         (ta_regpg || (ta_code == `CODE_WP));

  wire [9:0] cp_addr   = {ta_ff[9:5], cp_off_ff};
  wire       cp_ctrl   = (cp_addr >= `ADDR_PROT_BASE) && (cp_addr <= `ADDR_LOCK);
  // a self-locked code byte or a fixed byte is never reprogrammed
  wire       cp_skip   = (cp_addr > `ADDR_LOCK) ||
                         (cp_ctrl && is_lock_code(mem_ff[cp_addr]));

  // ***************************************************************
  // read path for the whole map
  // ***************************************************************
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `ERASED_BYTE;
    if (cmd_addr < `ADDR_FACTORY)
      rd_byte = mem_ff[cmd_addr];
    else if (cmd_addr == `ADDR_FACTORY)
      rd_byte = FACTORY_BYTE;
    else if (cmd_addr <= `ADDR_RSVD_LAST)
      rd_byte = mem_ff[cmd_addr];
    else if (cmd_addr == `ADDR_TRAILER0)
      rd_byte = TRAILER_BYTE0;
    else if (cmd_addr == `ADDR_TRAILER1)
      rd_byte = TRAILER_BYTE1;
    else if (cmd_addr == `ADDR_PIN_LEVEL)
      rd_byte = {`PIN_FILL_HI, pin_snap_ff};
    else if (cmd_addr == `ADDR_OUT_LATCH)
      rd_byte = {`PIN_FILL_HI, out_latch_ff};
    else if (cmd_addr == `ADDR_ACTIVITY)
      rd_byte = {6'h00, activity_ff};
    else if (cmd_addr == `ADDR_SRCH_MASK)
      rd_byte = {6'h00, srch_mask_ff};
    else if (cmd_addr == `ADDR_SRCH_POL)
      rd_byte = {6'h00, srch_pol_ff};
    else if (cmd_addr == `ADDR_SRCH_CTRL)
      rd_byte = {vcc_level, pol_level, srch_ctrl_ff[5:0]};
  end

  // ***************************************************************
  // pin and strap synchronisers
  // ***************************************************************
  // two stages before anything looks at an outside level
  // no reset: the stages keep sampling while rst is high, so the first
  // edge after release loads the real polarity strap into the latches
  always @(posedge sys_clk) begin
    pin_s1_ff   <= {gp_pin_one_in, gp_pin_zero_in};
    pin_s2_ff   <= pin_s1_ff;
    strap_s1_ff <= strap_bits;
    strap_s2_ff <= strap_s1_ff;
    pol_s1_ff   <= {vcc_present, powerup_polarity_strap};
    pol_s2_ff   <= pol_s1_ff;
  end

  // ***************************************************************
  // search compare
  // ***************************************************************
  wire [1:0] srch_src = srch_ctrl_ff[`CTRL_PLS_BIT] ? activity_ff : pin_s2_ff;
  wire [1:0] srch_hit = ~(srch_src ^ srch_pol_ff) & srch_mask_ff;
  wire       srch_and = ((srch_hit | ~srch_mask_ff) == 2'h3) &&
                        (srch_mask_ff != 2'h0);
  wire       srch_or  = |srch_hit;
  wire       srch_res = srch_ctrl_ff[`CTRL_PORL_BIT] ||
                        (srch_ctrl_ff[`CTRL_CT_BIT] ? srch_and : srch_or);

  wire go = cmd_valid && granted_ff && (state_ff == ST_IDLE);
  wire [1:0] edge_seen = pin_s2_ff ^ pin_d_ff;
  wire act_clear = go && (cmd_code == `CMD_ACT_RESET);

  // ***************************************************************
  // pin registers
  // ***************************************************************
  // volatile: every one of these returns to its power-up value on rst
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_d_ff      <= pin_s2_ff; // idle level, so no false edge
      pin_snap_ff   <= 2'h0;
      activity_ff   <= 2'h0;
      out_latch_ff  <= 2'h3;
      pol_caught_ff <= 1'b0;
      srch_mask_ff  <= 2'h0;
      srch_pol_ff   <= 2'h0;
      srch_ctrl_ff  <= 8'h08;
    end else begin
      pin_d_ff <= pin_s2_ff;
      // sampled when the byte before a pin read finishes
      if (byte_end)
        pin_snap_ff <= pin_s2_ff;
      // set wins over a clear in the same cycle
      activity_ff <= (act_clear ? 2'h0 : activity_ff) |
                     (pol_caught_ff ? edge_seen : 2'h0);
      if (!pol_caught_ff) begin
        pol_caught_ff <= 1'b1;
        out_latch_ff  <= {pol_level, pol_level};
      end else if (go && cmd_code == `CMD_PIN_WRITE)
        out_latch_ff <= cmd_data[1:0];
      if (go && cmd_code == `CMD_REG_WRITE) begin
        // the other pin registers ignore this command
        case (cmd_addr)
          `ADDR_SRCH_MASK: srch_mask_ff <= cmd_data[1:0];
          `ADDR_SRCH_POL:  srch_pol_ff  <= cmd_data[1:0];
          `ADDR_SRCH_CTRL: srch_ctrl_ff <= cmd_data & `CTRL_WR_MASK;
          default: ;
        endcase
      end
    end
  end

  // ***************************************************************
  // access grant and speed
  // ***************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      granted_ff <= 1'b0;
      overdrive  <= 1'b0;
    end else if (bus_reset) begin
      granted_ff <= 1'b0;
      if (!overdrive)
        overdrive <= 1'b0;
    end else if (rom_done) begin
      granted_ff <= 1'b1;
      if (rom_overdrive && !overdrive)
        overdrive <= 1'b1;
    end
  end

  // ***************************************************************
  // command engine, scratchpad and copy
  // ***************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff      <= ST_IDLE;
      ta_ff         <= 10'h000;
      end_ff        <= 5'h00;
      cp_off_ff     <= 5'h00;
      pad_fresh_ff  <= 1'b1;
      cp_blocked_ff <= 1'b0;
      resp_valid    <= 1'b0;
      resp_data     <= 8'h00;
      cmd_refused   <= 1'b0;
      busy          <= 1'b0;
      for (k = 0; k < 32; k = k + 1)
        pad_ff[k] <= `ERASED_BYTE;
      for (k = 0; k < `MEM_BYTES; k = k + 1)
        mem_ff[k] <= `ERASED_BYTE;
    end else begin
      resp_valid  <= 1'b0;
      cmd_refused <= cmd_valid && !granted_ff;
      case (state_ff)
        ST_IDLE: begin
          busy <= 1'b0;
          if (go) begin
            resp_valid <= 1'b1;
            resp_data  <= 8'h00;
            case (cmd_code)
              `CMD_READ_MEM: resp_data <= rd_byte;
              `CMD_SP_WRITE: begin
                if (pad_fresh_ff)
                  ta_ff <= cmd_addr;
                pad_fresh_ff <= 1'b0;
                end_ff <= cmd_addr[4:0];
                pad_ff[cmd_addr[4:0]] <= pad_value;
                resp_data <= pad_value;
              end
              `CMD_SP_READ: resp_data <= pad_ff[cmd_addr[4:0]];
              `CMD_SP_COPY: begin
                resp_valid   <= 1'b0;
                busy         <= 1'b1;
                pad_fresh_ff <= 1'b1;
                cp_off_ff    <= ta_ff[4:0];
                cp_blocked_ff <= ta_cprot;
                state_ff     <= ST_COPY;
              end
              `CMD_PIN_WRITE: resp_data <= cmd_data;
              `CMD_ACT_RESET: resp_data <= `STAT_DONE;
              `CMD_REG_WRITE: resp_data <= cmd_data;
              // lsb of byte 0 is bit index 0
              `CMD_ID_BIT: resp_data <= {7'h00, id_word[cmd_addr[5:0]]};
              default: resp_data <= `STAT_BLOCKED;
            endcase
          end
        end
        ST_COPY: begin
          // one byte per cycle; WP and EPROM pages are still refreshed
          if (!cp_blocked_ff && !cp_skip)
            mem_ff[cp_addr] <= pad_ff[cp_off_ff];
          if (cp_off_ff == end_ff) begin
            state_ff   <= ST_IDLE;
            busy       <= 1'b0;
            resp_valid <= 1'b1;
            resp_data  <= cp_blocked_ff ? `STAT_BLOCKED : `STAT_DONE;
          end else
            cp_off_ff <= cp_off_ff + 5'h01;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // pin drivers and search output
  // ***************************************************************
  // open drain: pull low while the latch holds 0
  always @(posedge sys_clk) begin
    if (rst) begin
      gp_pin_zero_out <= 1'b0;
      gp_pin_one_out  <= 1'b0;
      gp_pin_zero_oe  <= 1'b0;
      gp_pin_one_oe   <= 1'b0;
      search_match    <= 1'b0;
    end else begin
      gp_pin_zero_oe <= pol_caught_ff && !out_latch_ff[0];
      gp_pin_one_oe  <= pol_caught_ff && !out_latch_ff[1];
      search_match   <= srch_res;
    end
  end

endmodule // eeprom_page_protection_map

// ===== tb/eeprom_map_props.sv
`timescale 1ns/1ps
`include "eeprom_map_consts.vh"
// ****************************************
// checker on the top-level ports
// ****************************************
module eeprom_map_props (
  input wire       sys_clk,
  input wire       rst,
  input wire [6:0] strap_bits,
  input wire       powerup_polarity_strap,
  input wire       vcc_present,
  input wire       gp_pin_zero_in,
  input wire       gp_pin_one_in,
  input wire       gp_pin_zero_out,
  input wire       gp_pin_zero_oe,
  input wire       gp_pin_one_out,
  input wire       gp_pin_one_oe,
  input wire       bus_reset,
  input wire       rom_done,
  input wire       rom_overdrive,
  input wire       byte_end,
  input wire       cmd_valid,
  input wire [3:0] cmd_code,
  input wire [9:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire       resp_valid,
  input wire [7:0] resp_data,
  input wire       cmd_refused,
  input wire       busy,
  input wire       overdrive,
  input wire       search_match
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg  grant_ff;
  wire taken = cmd_valid && grant_ff && !busy;
  // grant follows the addressing handshake; a bus reset drops it
  always @(posedge sys_clk) begin
    if (rst || bus_reset)
      grant_ff <= 1'b0;
    else if (rom_done)
      grant_ff <= 1'b1;
  end
  a_refuse_no_grant: assert property (cmd_valid && !grant_ff |=>
    cmd_refused && !resp_valid) else $error("request without grant");
  a_answer_taken: assert property (taken && cmd_code != `CMD_SP_COPY
    |=> resp_valid) else $error("taken request got no answer");
  a_answer_cause: assert property (resp_valid |->
    $past(taken) || $past(busy)) else $error("answer without request");
  a_od_set: assert property (rom_done && rom_overdrive |=>
    overdrive) else $error("overdrive not entered");
  a_od_sticky: assert property (overdrive |=> overdrive)
    else $error("overdrive dropped");
  a_od_cause: assert property (!overdrive && !(rom_done &&
    rom_overdrive) |=> !overdrive) else $error("overdrive uncaused");
  a_copy_walk: assert property (taken && cmd_code == `CMD_SP_COPY
    |=> busy ##[1:33] (resp_valid && !busy)) else $error("copy stuck");
  a_copy_status: assert property (resp_valid && $past(busy) |->
    resp_data == `STAT_DONE || resp_data == `STAT_BLOCKED)
    else $error("copy status code wrong");
  a_pin_open_drain: assert property (!gp_pin_zero_out &&
    !gp_pin_one_out) else $error("pin driven high");
  a_pin_write_oe: assert property (taken && cmd_code == `CMD_PIN_WRITE
    |-> ##2 (gp_pin_zero_oe == !$past(cmd_data[0], 2)) &&
    (gp_pin_one_oe == !$past(cmd_data[1], 2)))
    else $error("pin latch not following write");
  a_powerup_oe: assert property ($fell(rst) |-> ##2
    (gp_pin_zero_oe == !$past(powerup_polarity_strap, 2)))
    else $error("pin latch power-up level wrong");
  c_copy: cover property (taken && cmd_code == `CMD_SP_COPY);
  c_refused: cover property (cmd_refused);
  c_pin_write: cover property (taken && cmd_code == `CMD_PIN_WRITE);
endmodule // eeprom_map_props

bind eeprom_page_protection_map eeprom_map_props i_eeprom_map_props (.*);

// ===== tb/bus_master_model.sv
`timescale 1ns/1ps
// ****************************************
// far-side bus master: addressing, then commands
// ****************************************
module bus_master_model (
  input  wire       sys_clk,
  input  wire       resp_valid,
  input  wire [7:0] resp_data,
  input  wire       cmd_refused,
  input  wire       busy,
  output reg        rom_done,
  output reg        rom_overdrive,
  output reg        byte_end,
  output reg        bus_reset,
  output reg        cmd_valid,
  output reg  [3:0] cmd_code,
  output reg  [9:0] cmd_addr,
  output reg  [7:0] cmd_data
);
  // idle bus at time zero
  initial begin
    {rom_done, rom_overdrive, byte_end, bus_reset, cmd_valid} = 5'h00;
    cmd_code = 4'h0;
    cmd_addr = 10'h000;
    cmd_data = 8'h00;
  end
  // one-cycle strobes; byte_end marks the last lsb-first bit of a byte
  task pulse(input [2:0] w, input od);
    begin
      @(posedge sys_clk);
      {bus_reset, byte_end, rom_done} <= w;
      rom_overdrive <= od;
      @(posedge sys_clk);
      {bus_reset, byte_end, rom_done} <= 3'b000;
      rom_overdrive <= 1'b0;
      @(negedge sys_clk);
    end
  endtask
  // st: 1 answered, 2 refused, 0 no reply within bound
  task op(input [3:0] c, input [9:0] a, input [7:0] d,
          output [7:0] q, output [1:0] st);
    integer n;
    begin
      st = 2'd0;
      q = 8'h00;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      // released lines must not keep looking valid
      cmd_addr <= ~a;
      cmd_data <= ~d;
      for (n = 0; n < 40 && st == 2'd0; n = n + 1) begin
        @(negedge sys_clk);
        if (resp_valid === 1'b1) begin
          st = 2'd1;
          q = resp_data;
        end else if (cmd_refused === 1'b1)
          st = 2'd2;
      end
    end
  endtask
endmodule // bus_master_model

// ===== tb/test_eeprom_page_protection_map.sv
`timescale 1ns/1ps
`include "eeprom_map_consts.vh"
`define CHK(nm, ex, sn) begin checked = checked + 1; \
  if ((sn) !== (ex)) begin num_errors = num_errors + 1; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end
// ****************************************
// bench: command sequences with expected values
// ****************************************
module test_eeprom_page_protection_map;
  localparam [7:0]  FAM = 8'h3C; // arbitrary value
  localparam [39:0] SER = 40'hA1B2C3D4E5; // arbitrary value
  reg        sys_clk, rst, ext0, ext1, powerup_polarity_strap, vcc_present;
  reg  [6:0] strap_bits;
  wire       gp_pin_zero_out, gp_pin_zero_oe, gp_pin_one_out, gp_pin_one_oe;
  wire       bus_reset, rom_done, rom_overdrive, byte_end, cmd_valid;
  wire [3:0] cmd_code;
  wire [9:0] cmd_addr;
  wire [7:0] cmd_data, resp_data;
  wire       resp_valid, cmd_refused, busy, overdrive, search_match;
  // open-drain pins: external level unless the device pulls low
  wire       gp_pin_zero_in = ext0 & ~gp_pin_zero_oe;
  wire       gp_pin_one_in = ext1 & ~gp_pin_one_oe;
  integer    num_errors, checked, i;
  reg  [7:0] q;
  reg  [1:0] st;
  reg [63:0] id;
  reg [63:0] id_exp;
  eeprom_page_protection_map #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER))
    i_eeprom_page_protection_map (.*);
  bus_master_model i_bus_master_model (.*);
  // reflected crc, one input bit at a time, lsb first
  function [7:0] crc8(input [55:0] v);
    integer k;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (k = 0; k < 56; k = k + 1)
        c = (c[0] ^ v[k]) ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
      crc8 = c;
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // a command that runs out of its reply bound counts as a mismatch
  task cmd(input [3:0] c, input [9:0] a, input [7:0] d);
    begin
      i_bus_master_model.op(c, a, d, q, st);
      `CHK("reply", 1'b1, st != 2'd0)
    end
  endtask
  task rd(input [9:0] a, input [7:0] e);
    begin
      cmd(`CMD_READ_MEM, a, 8'h00);
      `CHK("read", e, q)
    end
  endtask
  // scratch write, read back, then copy of a single byte
  task sc(input [9:0] a, input [7:0] d, input [7:0] e_sp, input [7:0] e_st);
    begin
      cmd(`CMD_SP_WRITE, a, d);
      `CHK("scratch", e_sp, q)
      cmd(`CMD_SP_READ, a, 8'h00);
      `CHK("pad readback", e_sp, q)
      cmd(`CMD_SP_COPY, a, 8'h00);
      `CHK("copy", e_st, q)
    end
  endtask
  // clock and a watchdog sized well above the sequence length
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    $display("Error watchdog expected done seen hang");
    test_done;
  end
  initial begin
    {num_errors, checked} = 0;
    {rst, ext0, ext1, powerup_polarity_strap, vcc_present} = 5'h1F;
    strap_bits = 7'h35;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmd(`CMD_READ_MEM, 10'h000, 8'h00);
    `CHK("no grant", 2'd2, st)
    i_bus_master_model.pulse(3'b001, 1'b1);
    `CHK("overdrive", 1'b1, overdrive)
    for (i = 0; i < 64; i = i + 1) begin
      cmd(`CMD_ID_BIT, i[9:0], 8'h00);
      id[i] = q[0];
    end
    id_exp = {crc8({SER, 8'h7F, FAM}), SER, 8'h35, FAM};
    `CHK("identity", id_exp, id)
    cmd(4'h0, 10'h000, 8'h00);
    `CHK("unknown code", `STAT_BLOCKED, q)
    sc(10'h040, 8'hF0, 8'hF0, `STAT_DONE);
    sc(10'h201, `CODE_WP, `CODE_WP, `STAT_DONE);
    sc(10'h202, `CODE_EPROM, `CODE_EPROM, `STAT_DONE);
    sc(10'h020, 8'h00, 8'hFF, `STAT_DONE);
    sc(10'h040, 8'h0F, 8'h00, `STAT_DONE);
    sc(10'h201, 8'h12, `CODE_WP, `STAT_DONE);
    sc(10'h203, 8'h12, 8'h12, `STAT_DONE);
    sc(10'h060, 8'h3C, 8'h3C, `STAT_DONE);
    rd(10'h203, 8'h12);
    rd(10'h060, 8'h3C);
    sc(10'h210, `CODE_WP, `CODE_WP, `STAT_DONE);
    sc(10'h020, 8'h00, 8'hFF, `STAT_BLOCKED);
    sc(10'h040, 8'hFF, 8'h00, `STAT_DONE);
    sc(10'h203, 8'h34, 8'h34, `STAT_BLOCKED);
    rd(10'h203, 8'h12);
    rd(10'h211, 8'h55);
    rd(10'h1FF, 8'hFF);
    // pins idle high since power-up: no activity may be latched
    rd(10'h222, 8'h00);
    cmd(`CMD_ACT_RESET, 10'h000, 8'h00);
    @(posedge sys_clk);
    ext0 <= 1'b0;
    repeat (4) @(posedge sys_clk);
    i_bus_master_model.pulse(3'b010, 1'b0);
    @(posedge sys_clk);
    ext0 <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(10'h220, 8'hFE);
    rd(10'h222, 8'h01);
    cmd(`CMD_ACT_RESET, 10'h000, 8'h00);
    rd(10'h222, 8'h00);
    cmd(`CMD_PIN_WRITE, 10'h000, 8'h02);
    rd(10'h221, 8'hFE);
    rd(10'h225, 8'hC8);
    cmd(`CMD_REG_WRITE, 10'h223, 8'hFF);
    rd(10'h223, 8'h03);
    cmd(`CMD_REG_WRITE, 10'h225, 8'h00);
    rd(10'h225, 8'hC0);
    // pin zero is pulled low by its latch: it matches polarity 0
    `CHK("match any", 1'b1, search_match)
    cmd(`CMD_REG_WRITE, 10'h224, 8'h01);
    rd(10'h224, 8'h01);
    `CHK("match none", 1'b0, search_match)
    cmd(`CMD_REG_WRITE, 10'h221, 8'h01);
    rd(10'h221, 8'hFE);
    i_bus_master_model.pulse(3'b100, 1'b0);
    cmd(`CMD_READ_MEM, 10'h000, 8'h00);
    `CHK("bus reset", 2'd2, st)
    test_done;
  end
endmodule // test_eeprom_page_protection_map
